// ==== hdl/eodec_pkg.sv ====
// constants, opcode patterns and carrier types for the enhanced op decoder
// assumes a single 25 mhz system clock shared with the program memory port
package eodec_pkg;

    // ****************************************************************
    // word layout
    // ****************************************************************
    localparam int unsigned EODEC_WORD_W = 14;
    localparam int unsigned EODEC_LIT_W = 8;
    localparam int unsigned EODEC_OFS_W = 6;
    localparam int unsigned EODEC_ADR_W = 11;
    localparam int unsigned EODEC_BRA_W = 9;
    localparam int unsigned EODEC_PTR_BIT = 6;
    localparam int unsigned EODEC_CNT_W = 2;

    // ****************************************************************
    // exact opcodes
    // ****************************************************************
    localparam logic [13:0] OPC_NOP = 14'h0000;
    localparam logic [13:0] OPC_RESET = 14'h0001;
    localparam logic [13:0] OPC_RETURN = 14'h0008;
    localparam logic [13:0] OPC_RETFIE = 14'h0009;
    localparam logic [13:0] OPC_CALL_ACC = 14'h000a;
    localparam logic [13:0] OPC_BRANCH_ACC = 14'h000b;
    localparam logic [13:0] OPC_LOAD_CFG = 14'h0062;
    localparam logic [13:0] OPC_STANDBY = 14'h0063;
    localparam logic [13:0] OPC_CLR_WDOG = 14'h0064;

    // ****************************************************************
    // prefix patterns (upper bits of the word)
    // ****************************************************************
    localparam logic [10:0] PFX_PIN_DIR = 11'h00c;  // bits 13:3
    localparam logic [10:0] PFX_IND_LOAD = 11'h002; // bits 13:3
    localparam logic [10:0] PFX_IND_STORE = 11'h003; // bits 13:3
    localparam logic [5:0] PFX_RET_LIT = 6'h34;     // bits 13:8
    localparam logic [6:0] PFX_PTR_ADD = 7'h62;     // bits 13:7
    localparam logic [6:0] PFX_IDX_LOAD = 7'h7e;    // bits 13:7
    localparam logic [6:0] PFX_IDX_STORE = 7'h7f;   // bits 13:7
    localparam logic [4:0] PFX_BRANCH = 5'h19;      // bits 13:9
    localparam logic [2:0] PFX_CALL = 3'h4;         // bits 13:11
    localparam logic [2:0] PFX_GOTO = 3'h5;         // bits 13:11

    // ****************************************************************
    // cycle counts and reset values
    // ****************************************************************
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CNT_RST = 2'h0;

    // decoded operation classes
    typedef enum logic [4:0] {
        OP_NONE, OP_NOP, OP_RESET, OP_RETURN, OP_RETFIE,
        OP_CALL_BY_ACC, OP_BRANCH_BY_ACC, OP_LOAD_CONFIG_REG, OP_STANDBY,
        OP_CLEAR_WATCHDOG, OP_LOAD_PIN_DIRECTION, OP_RETURN_LITERAL,
        OP_POINTER_ADD_LITERAL, OP_INDIRECT_LOAD, OP_INDIRECT_STORE,
        OP_INDEXED_LOAD, OP_INDEXED_STORE, OP_BRANCH, OP_CALL, OP_GOTO,
        OP_UNKNOWN
    } eodec_op_t;

    // word from program memory plus the core's test outcome
    typedef struct packed {
        logic [13:0] word;
        logic test_true;
    } eodec_fetch_t;

    // decoded result handed to the execution core
    typedef struct packed {
        eodec_op_t op;
        logic ptr_sel;
        logic [1:0] modifier;
        logic [5:0] offset;
        logic [7:0] literal;
        logic [2:0] reg_sel;
        logic [10:0] target;
        logic [1:0] cycles;
        logic upd_null_flag;
        logic upd_wdog_flags;
        logic pc_changes;
    } eodec_dec_t;

endpackage

// ==== hdl/eodec_decoder.sv ====
// enhanced op decoder: classifies fourteen-bit words, fills operand fields,
// states cycle count and which status flags change, then idles extra cycles.
// assumes program memory and core share clk_sys; pointer top bits come from
// the core's indirect pointers on the same clock, so no synchronisers.
module eodec_decoder
    import eodec_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // program memory side
    input wire logic fetch_valid,
    input wire eodec_fetch_t fetch_in,
    output logic fetch_ready_ff,
    // indirect pointer top bits, one per pointer
    input wire logic [1:0] ptr_top_bit,
    // decoded output to the core
    output logic dec_valid_ff,
    output eodec_dec_t dec_ff,
    output logic idle_cycle_ff
);

    // ****************************************************************
    // combinational decode of the incoming word
    // ****************************************************************
    eodec_dec_t dec_c;
    logic [13:0] w;
    logic extra_ptr;
    logic hit_pin_dir;
    logic hit_ind_load;
    logic hit_ind_store;
    logic hit_ret_lit;
    logic hit_ptr_add;
    logic hit_idx_load;
    logic hit_idx_store;
    logic hit_branch;
    logic hit_call;
    logic hit_goto;

    // class matches on the top bits; operand bits below are left alone
    eodec_prefix_match #(
        .PFX_W($bits(PFX_PIN_DIR)),
        .PATTERN(PFX_PIN_DIR)
    ) u_pfx_pin_dir (
        .word(fetch_in.word),
        .hit(hit_pin_dir)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_IND_LOAD)),
        .PATTERN(PFX_IND_LOAD)
    ) u_pfx_ind_load (
        .word(fetch_in.word),
        .hit(hit_ind_load)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_IND_STORE)),
        .PATTERN(PFX_IND_STORE)
    ) u_pfx_ind_store (
        .word(fetch_in.word),
        .hit(hit_ind_store)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_RET_LIT)),
        .PATTERN(PFX_RET_LIT)
    ) u_pfx_ret_lit (
        .word(fetch_in.word),
        .hit(hit_ret_lit)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_PTR_ADD)),
        .PATTERN(PFX_PTR_ADD)
    ) u_pfx_ptr_add (
        .word(fetch_in.word),
        .hit(hit_ptr_add)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_IDX_LOAD)),
        .PATTERN(PFX_IDX_LOAD)
    ) u_pfx_idx_load (
        .word(fetch_in.word),
        .hit(hit_idx_load)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_IDX_STORE)),
        .PATTERN(PFX_IDX_STORE)
    ) u_pfx_idx_store (
        .word(fetch_in.word),
        .hit(hit_idx_store)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_BRANCH)),
        .PATTERN(PFX_BRANCH)
    ) u_pfx_branch (
        .word(fetch_in.word),
        .hit(hit_branch)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_CALL)),
        .PATTERN(PFX_CALL)
    ) u_pfx_call (
        .word(fetch_in.word),
        .hit(hit_call)
    );
    eodec_prefix_match #(
        .PFX_W($bits(PFX_GOTO)),
        .PATTERN(PFX_GOTO)
    ) u_pfx_goto (
        .word(fetch_in.word),
        .hit(hit_goto)
    );

    // exact words first, since several sit inside wider prefix ranges
    always_comb begin
        w = fetch_in.word;
        dec_c = '0;
        dec_c.op = OP_UNKNOWN;
        dec_c.cycles = CYC_ONE;
        dec_c.ptr_sel = w[EODEC_PTR_BIT];
        dec_c.modifier = w[1:0];
        dec_c.offset = w[EODEC_OFS_W-1:0];
        dec_c.literal = w[EODEC_LIT_W-1:0];
        dec_c.reg_sel = w[2:0];
        dec_c.target = w[EODEC_ADR_W-1:0];
        extra_ptr = 1'b0;
        if (w == OPC_NOP) begin
            dec_c.op = OP_NOP;
        end else if (w == OPC_RESET) begin
            dec_c.op = OP_RESET;
        end else if (w == OPC_RETURN) begin
            dec_c.op = OP_RETURN;
            dec_c.pc_changes = 1'b1;
        end else if (w == OPC_RETFIE) begin
            dec_c.op = OP_RETFIE;
            dec_c.pc_changes = 1'b1;
        end else if (w == OPC_CALL_ACC) begin
            dec_c.op = OP_CALL_BY_ACC;
            dec_c.pc_changes = 1'b1;
        end else if (w == OPC_BRANCH_ACC) begin
            dec_c.op = OP_BRANCH_BY_ACC;
            dec_c.pc_changes = 1'b1;
        end else if (w == OPC_LOAD_CFG) begin
            dec_c.op = OP_LOAD_CONFIG_REG;
        end else if (w == OPC_STANDBY) begin
            dec_c.op = OP_STANDBY;
            dec_c.upd_wdog_flags = 1'b1;
        end else if (w == OPC_CLR_WDOG) begin
            dec_c.op = OP_CLEAR_WATCHDOG;
            dec_c.upd_wdog_flags = 1'b1;
        end else if (hit_pin_dir) begin
            dec_c.op = OP_LOAD_PIN_DIRECTION;
        end else if (hit_ind_load) begin
            dec_c.op = OP_INDIRECT_LOAD;
            dec_c.ptr_sel = w[2];
            dec_c.upd_null_flag = 1'b1;
            extra_ptr = 1'b1;
        end else if (hit_ind_store) begin
            dec_c.op = OP_INDIRECT_STORE;
            dec_c.ptr_sel = w[2];
            extra_ptr = 1'b1;
        end else if (hit_ret_lit) begin
            dec_c.op = OP_RETURN_LITERAL;
            dec_c.pc_changes = 1'b1;
        end else if (hit_ptr_add) begin
            dec_c.op = OP_POINTER_ADD_LITERAL;
        end else if (hit_idx_load) begin
            dec_c.op = OP_INDEXED_LOAD;
            dec_c.upd_null_flag = 1'b1;
            extra_ptr = 1'b1;
        end else if (hit_idx_store) begin
            dec_c.op = OP_INDEXED_STORE;
            extra_ptr = 1'b1;
        end else if (hit_branch) begin
            dec_c.op = OP_BRANCH;
            dec_c.target = {2'h0, w[EODEC_BRA_W-1:0]};
            dec_c.pc_changes = 1'b1;
        end else if (hit_call) begin
            dec_c.op = OP_CALL;
            dec_c.pc_changes = 1'b1;
        end else if (hit_goto) begin
            dec_c.op = OP_GOTO;
            dec_c.pc_changes = 1'b1;
        end
        // a pc change or a true test costs a second, idle cycle
        if (dec_c.pc_changes || fetch_in.test_true) begin
            dec_c.cycles = CYC_TWO;
        end
        // pointer with its top bit set reaches slow memory: one more cycle
        if (extra_ptr && ptr_top_bit[dec_c.ptr_sel]) begin
            dec_c.cycles = dec_c.cycles + CYC_ONE;
        end
    end

    // ****************************************************************
    // sequencing state machine
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b010,
        ST_IDLE = 3'b100
    } eodec_state_t;

    eodec_state_t state_ff;
    eodec_state_t nxt_state;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic nxt_fetch_ready;
    logic nxt_dec_valid;
    logic nxt_idle_cycle;
    eodec_dec_t nxt_dec;

    // one clock is one instruction cycle; extra cycles are idle slots
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_dec = dec_ff;
        nxt_dec_valid = 1'b0;
        nxt_idle_cycle = 1'b0;
        nxt_fetch_ready = 1'b0;
        case (state_ff)
            ST_FETCH: begin
                nxt_fetch_ready = 1'b1;
                if (fetch_valid && fetch_ready_ff) begin
                    nxt_dec = dec_c;
                    nxt_dec_valid = 1'b1;
                    nxt_fetch_ready = 1'b0;
                    nxt_cnt = dec_c.cycles - CYC_ONE;
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (cnt_ff == CNT_RST) begin
                    nxt_state = ST_FETCH;
                    nxt_fetch_ready = 1'b1;
                end else begin
                    // second and later cycles do nothing but wait
                    nxt_idle_cycle = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cnt_ff == CYC_ONE) begin
                    nxt_cnt = CNT_RST;
                    nxt_state = ST_FETCH;
                    nxt_fetch_ready = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - CYC_ONE;
                    nxt_idle_cycle = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_FETCH;
                nxt_cnt = CNT_RST;
            end
        endcase
    end

    // registers only; after reset the block waits in fetch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_FETCH;
            cnt_ff <= CNT_RST;
            dec_ff <= '0;
            dec_valid_ff <= 1'b0;
            idle_cycle_ff <= 1'b0;
            fetch_ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            dec_ff <= nxt_dec;
            dec_valid_ff <= nxt_dec_valid;
            idle_cycle_ff <= nxt_idle_cycle;
            fetch_ready_ff <= nxt_fetch_ready;
        end
    end

endmodule

// ****************************************************************
// prefix comparator for opcode classes known by their top bits
// ****************************************************************
// one copy per class keeps every compare the same shape; the decoder
// still ranks the hits, since exact words sit inside some prefixes
module eodec_prefix_match
    import eodec_pkg::*;
#(
    parameter int unsigned PFX_W = 6,
    parameter logic [PFX_W-1:0] PATTERN = '0
)
(
    // word under decode
    input wire logic [EODEC_WORD_W-1:0] word,
    // class match
    output logic hit
);

    // top bits only; the bits below carry operands
    assign hit = (word[EODEC_WORD_W-1 -: PFX_W] == PATTERN);

endmodule

// ==== tb/eodec_decoder_chk.sv ====
// checker for the enhanced op decoder: decode timing and flag relations
// assumes it is bound to eodec_decoder and sees only that module's ports
module eodec_decoder_chk
    import eodec_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // program memory side
    input wire logic fetch_valid,
    input wire eodec_fetch_t fetch_in,
    input wire logic fetch_ready_ff,
    input wire logic [1:0] ptr_top_bit,
    // decoded output
    input wire logic dec_valid_ff,
    input wire eodec_dec_t dec_ff,
    input wire logic idle_cycle_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic take;
    logic t;
    logic [13:0] w;
    logic [7:0] lit;
    // shorthands for the take edge and the word seen there
    assign take = fetch_valid && fetch_ready_ff;
    assign w = fetch_in.word;
    assign t = fetch_in.test_true;
    assign lit = fetch_in.word[7:0];
    // a two-cycle op idles once and then asks for the next word
    sequence s_two;
        dec_valid_ff && dec_ff.cycles == CYC_TWO;
    endsequence
    sequence s_idle_ready;
        idle_cycle_ff ##1 (fetch_ready_ff && !idle_cycle_ff);
    endsequence
    a_answer_next: assert property (take |=> dec_valid_ff && !fetch_ready_ff)
        else $error("decode missing one cycle after take");
    a_branch_acc_two: assert property (
        take && w == OPC_BRANCH_ACC |=> dec_ff.op == OP_BRANCH_BY_ACC && dec_ff.cycles == CYC_TWO)
        else $error("branch by accumulator decode wrong");
    a_ret_lit_value: assert property (
        take && w[13:8] == PFX_RET_LIT |=> dec_ff.literal == $past(lit) && dec_ff.cycles == CYC_TWO)
        else $error("return literal decode wrong");
    a_standby_flags: assert property (
        take && w == OPC_STANDBY && !t |=> dec_ff.upd_wdog_flags && dec_ff.cycles == CYC_ONE)
        else $error("standby decode wrong");
    a_ptr_add_quiet: assert property (
        take && w[13:7] == PFX_PTR_ADD && !t
        |=> dec_ff.cycles == CYC_ONE && !dec_ff.upd_null_flag && !dec_ff.upd_wdog_flags)
        else $error("pointer add decode wrong");
    a_ind_load_null: assert property (
        take && w[13:3] == PFX_IND_LOAD |=> dec_ff.op == OP_INDIRECT_LOAD && dec_ff.upd_null_flag)
        else $error("indirect load decode wrong");
    a_idx_load_null: assert property (
        take && w[13:7] == PFX_IDX_LOAD |=> dec_ff.op == OP_INDEXED_LOAD && dec_ff.upd_null_flag)
        else $error("indexed load decode wrong");
    a_two_cycle_idle: assert property (s_two |=> s_idle_ready)
        else $error("two-cycle op not followed by one idle");
    a_top_bit_extra: assert property (
        take && w[13:7] == PFX_IDX_STORE && ptr_top_bit[w[6]] && !t |=> dec_ff.cycles == CYC_TWO)
        else $error("pointer top bit gave no extra cycle");
endmodule

bind eodec_decoder eodec_decoder_chk u_chk (.clk_sys, .resetn, .fetch_valid, .fetch_in,
    .fetch_ready_ff, .ptr_top_bit, .dec_valid_ff, .dec_ff, .idle_cycle_ff);

// ==== tb/eodec_pmem_model.sv ====
// program memory model: offers one word at a time on the fetch port
// assumes the bench refreshes next_word and gap at every take edge
module eodec_pmem_model
    import eodec_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bench control
    input wire eodec_fetch_t next_word,
    input wire logic [2:0] gap,
    // fetch port
    input wire logic fetch_ready_ff,
    output logic fetch_valid,
    output eodec_fetch_t fetch_in
);
    logic [2:0] wait_ff;
    // hold the offer until taken; a stalled bus shows a scrambled word
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fetch_valid <= 1'b0;
            fetch_in <= '0;
            wait_ff <= 3'h0;
        end else if (fetch_valid && fetch_ready_ff) begin
            fetch_valid <= 1'b0;
            fetch_in <= ~fetch_in;
            wait_ff <= gap;
        end else if (!fetch_valid && wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
            fetch_in <= ~fetch_in;
        end else if (!fetch_valid) begin
            fetch_valid <= 1'b1;
            fetch_in <= next_word;
        end
    end
endmodule

// ==== tb/test_enhanced_op_decoder.sv ====
// bench for the enhanced op decoder: reference model compared at every decode
// assumes the memory model stalls between words and the pointer bits hold per word
module test_enhanced_op_decoder
    import eodec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, resetn = 1'b0, fetch_valid, fetch_ready_ff, dec_valid_ff, idle_cycle_ff;
    logic [1:0] ptr_top_bit = 2'h3;
    logic [2:0] gap = 3'h0;
    eodec_fetch_t fetch_in, next_word = '0;
    eodec_dec_t dec_ff;
    int fail_count = 0, n_tests = 0, idles = 0, prev_cyc = 0, q_op[$], q_cyc[$], q_kind[$],
        q_val[$], q_fl[$];
    eodec_pmem_model u_mem (.clk_sys, .resetn, .next_word, .gap, .fetch_ready_ff, .fetch_valid,
        .fetch_in);
    eodec_decoder DUT (.clk_sys, .resetn, .fetch_valid, .fetch_in, .fetch_ready_ff, .ptr_top_bit,
        .dec_valid_ff, .dec_ff, .idle_cycle_ff);
    initial forever #20 clk_sys = ~clk_sys;
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // word of class c with random fields r; pin field avoids the exact words
    function automatic logic [13:0] make_word(input int c, input logic [13:0] r);
        case (c)
            0: return 14'h000b;
            1: return 14'h000a;
            2: return {6'h34, r[7:0]};
            3: return 14'h0062;
            4: return {11'h00c, r[0], r[0], r[1]};
            5: return 14'h0063;
            6: return {7'h62, r[6:0]};
            7: return {11'h002, r[2:0]};
            8: return {11'h003, r[2:0]};
            9: return {7'h7e, r[6:0]};
            default: return {7'h7f, r[6:0]};
        endcase
    endfunction
    // reference decode: op, cycles, operand field kind and value, three-bit flag word
    task automatic expect_word(input logic [13:0] w, input logic t, input logic [1:0] pb);
        int op, pc, ind, sel, kind, fl;
        {pc, ind, sel, kind, fl} = '0;
        if (w == 14'h000b) {op, pc} = {32'(OP_BRANCH_BY_ACC), 32'h1};
        else if (w == 14'h000a) {op, pc} = {32'(OP_CALL_BY_ACC), 32'h1};
        else if (w == 14'h0062) op = OP_LOAD_CONFIG_REG;
        else if (w == 14'h0063) {op, fl} = {32'(OP_STANDBY), 32'h2};
        else if (w[13:8] == 6'h34) {op, pc, kind} = {32'(OP_RETURN_LITERAL), 32'h1, 32'h1};
        else if (w[13:3] == 11'h00c) {op, kind} = {32'(OP_LOAD_PIN_DIRECTION), 32'h2};
        else if (w[13:7] == 7'h62) {op, kind} = {32'(OP_POINTER_ADD_LITERAL), 32'h3};
        else if (w[13:4] == 10'h001) {op, kind, ind, sel} = {32'(w[3] ? OP_INDIRECT_STORE :
            OP_INDIRECT_LOAD), 32'h4, 32'h1, 31'h0, w[2]};
        else {op, kind, ind, sel} = {32'(w[7] ? OP_INDEXED_STORE : OP_INDEXED_LOAD), 32'h3,
            32'h1, 31'h0, w[6]};
        if ((op == OP_INDIRECT_LOAD || op == OP_INDEXED_LOAD)) fl = 1;
        // bit 2 of the flag word marks a program counter change
        fl = fl + 4 * pc;
        q_op.push_back(op);
        q_cyc.push_back(((pc || t) ? 2 : 1) + (ind && pb[sel]));
        q_kind.push_back(kind);
        q_val.push_back(kind == 1 ? w[7:0] : (kind == 3 ? w[6:0] : w[2:0]));
        q_fl.push_back(fl);
    endtask
    // compare each decode; idle pulses are counted against the previous op
    always @(posedge clk_sys) begin
        if (resetn && dec_valid_ff && q_op.size() > 0) begin
            if (prev_cyc > 0) check("idle", 8'(prev_cyc - 1), 8'(idles));
            check("op", 8'(q_op[0]), {3'h0, dec_ff.op});
            check("cycles", 8'(q_cyc[0]), {6'h0, dec_ff.cycles});
            check("flags", 8'(q_fl[0]),
                {5'h0, dec_ff.pc_changes, dec_ff.upd_wdog_flags, dec_ff.upd_null_flag});
            case (q_kind[0])
                1: check("literal", 8'(q_val[0]), dec_ff.literal);
                2: check("reg_sel", 8'(q_val[0]), {5'h0, dec_ff.reg_sel});
                3: check("offset", 8'(q_val[0]), {1'b0, dec_ff.ptr_sel, dec_ff.offset});
                4: check("mode", 8'(q_val[0]), {5'h0, dec_ff.ptr_sel, dec_ff.modifier});
                default: ;
            endcase
            {prev_cyc, idles} = {q_cyc.pop_front(), 32'd0};
            void'(q_op.pop_front());
            void'(q_kind.pop_front());
            void'(q_val.pop_front());
            void'(q_fl.pop_front());
        end else if (idle_cycle_ff) idles++;
    end
    // directed pass over all classes with both pointer top bits set, then random words
    initial begin
        int c, k;
        void'($urandom(53293));
        next_word = {make_word(0, 14'h0), 1'b0};
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 1; i <= 411; i++) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                if (++k > 20) fail_count++;
            end while (!(fetch_valid && fetch_ready_ff) && k <= 20);
            expect_word(fetch_in.word, fetch_in.test_true, ptr_top_bit);
            c = (i < 11) ? i : $urandom % 11;
            next_word <= {make_word(c, 14'($urandom)), (i < 11) ? 1'b0 : 1'($urandom)};
            ptr_top_bit <= (i < 11) ? 2'h3 : 2'($urandom);
            gap <= 3'($urandom % 4);
        end
        repeat (8) @(posedge clk_sys);
        report_and_stop();
    end
    // hang guard: roughly ten times the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end
endmodule
